// *** design/dmasc_pkg.sv ***
// Package with register map, field layout and codes for the short address DMA channel control.
package dmasc_pkg;
	localparam logic [7:0] DMASC_ADDR_PERIPH = 8'h26;
	localparam logic [7:0] DMASC_ADDR_CTRL = 8'h27;
	localparam logic [7:0] DMASC_ADDR_MAR0 = 8'h20;
	localparam logic [7:0] DMASC_ADDR_MAR1 = 8'h21;
	localparam logic [7:0] DMASC_ADDR_MAR2 = 8'h22;
	localparam logic [7:0] DMASC_ADDR_MAR3 = 8'h23;
	localparam logic [7:0] DMASC_ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0] DMASC_ADDR_IRQ_MASK = 8'h29;
	localparam logic [7:0] DMASC_CTRL_RESET = 8'h00;
	localparam logic [7:0] DMASC_PERIPH_RESET = 8'h00;
	localparam logic [7:0] DMASC_IRQ_RESET = 8'h00;
	localparam logic [31:0] DMASC_MAR_RESET = 32'h00000000;
	localparam logic [7:0] DMASC_READ_ZERO = 8'h00;
	localparam int DMASC_BIT_ENABLE = 7;
	localparam int DMASC_BIT_SIZE = 6;
	localparam int DMASC_BIT_DIR = 5;
	localparam int DMASC_BIT_REPEAT = 4;
	localparam int DMASC_BIT_IRQEN = 3;
	localparam int DMASC_SEL_HI = 2;
	localparam int DMASC_SEL_LO = 0;
	localparam int DMASC_IRQ_BIT_END = 0;
	localparam int DMASC_IRQ_BIT_XFER = 1;
	localparam logic [31:0] DMASC_STEP_BYTE = 32'h00000001;
	localparam logic [31:0] DMASC_STEP_WORD = 32'h00000002;
	localparam logic [2:0] DMASC_SEL_TXE = 3'h4;
	localparam logic [2:0] DMASC_SEL_RXF = 3'h5;
	typedef enum logic [1:0] {
		DMASC_MODE_IO = 2'h0,
		DMASC_MODE_REPEAT = 2'h1,
		DMASC_MODE_IDLE = 2'h3
	} dmasc_mode_t;
endpackage : dmasc_pkg

// *** design/dmasc_req_sel.sv ***
// Activation source selector that picks one on-chip request line.
`timescale 1ns/10ps
module dmasc_req_sel
	import dmasc_pkg::*;
(
	input wire logic [2:0] i_sel,
	input wire logic [3:0] i_timer_req,
	input wire logic i_txe_req,
	input wire logic i_rxf_req,
	output logic o_req,
	output logic o_full_mode
);
	// Top bit low picks a timer channel; codes 6 and 7 hand the pair to full address mode.
	always_comb begin
		o_req = 1'b0;
		o_full_mode = 1'b0;
		if (!i_sel[2]) begin
			o_req = i_timer_req[i_sel[1:0]];
		end else if (i_sel == DMASC_SEL_TXE) begin
			o_req = i_txe_req;
		end else if (i_sel == DMASC_SEL_RXF) begin
			o_req = i_rxf_req;
		end else begin
			o_full_mode = 1'b1;
		end
	end
endmodule : dmasc_req_sel

// *** design/dmasc_chan.sv ***
// Channel control register, request selection and address stepping for one short address channel.
`timescale 1ns/10ps
module dmasc_chan
	import dmasc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_timer_req,
	input wire logic i_txe_req,
	input wire logic i_rxf_req,
	input wire logic i_count_done,
	output logic [7:0] o_rdata,
	output logic o_xfer_start,
	output logic o_full_mode,
	output logic [1:0] o_mode,
	output logic [31:0] o_mem_addr,
	output logic [7:0] o_periph_addr,
	output logic o_irq
);
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [7:0] periph_ff, nxt_periph;
	logic [31:0] mar_ff, nxt_mar;
	logic [1:0] stat_ff, nxt_stat;
	logic [1:0] mask_ff, nxt_mask;
	logic [7:0] rdata_ff, nxt_rdata;
	logic start_ff, nxt_start;
	logic full_ff, nxt_full;
	logic [1:0] mode_ff, nxt_mode;
	logic irq_ff, nxt_irq;
	logic sel_req;
	logic sel_full;
	logic fire;
	logic end_evt;
	logic [31:0] step;

	// Request line chosen by the activation code.
	dmasc_req_sel u_sel (
		.i_sel(ctrl_ff[DMASC_SEL_HI:DMASC_SEL_LO]),
		.i_timer_req(i_timer_req),
		.i_txe_req(i_txe_req),
		.i_rxf_req(i_rxf_req),
		.o_req(sel_req),
		.o_full_mode(sel_full)
	);

	// A transfer starts only while enabled and in short address mode.
	assign fire = ctrl_ff[DMASC_BIT_ENABLE] & sel_req & ~sel_full;
	// Hardware ends the transfer when the counter runs out, clearing the enable bit.
	assign end_evt = ctrl_ff[DMASC_BIT_ENABLE] & i_count_done;
	// Word transfers step by two; decrement mirrors the increment.
	assign step = ctrl_ff[DMASC_BIT_SIZE] ? DMASC_STEP_WORD : DMASC_STEP_BYTE;

	// Register file next state; hardware events win over software clears.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_periph = periph_ff;
		nxt_mar = mar_ff;
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		nxt_rdata = DMASC_READ_ZERO;
		if (i_wr) begin
			unique case (i_addr)
				DMASC_ADDR_CTRL: nxt_ctrl = i_wdata;
				DMASC_ADDR_PERIPH: begin
					if (!sel_full) begin
						nxt_periph = i_wdata;
					end
				end
				DMASC_ADDR_MAR0: nxt_mar[31:24] = i_wdata;
				DMASC_ADDR_MAR1: nxt_mar[23:16] = i_wdata;
				DMASC_ADDR_MAR2: nxt_mar[15:8] = i_wdata;
				DMASC_ADDR_MAR3: nxt_mar[7:0] = i_wdata;
				DMASC_ADDR_IRQ_MASK: nxt_mask = i_wdata[1:0];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				DMASC_ADDR_CTRL: nxt_rdata = ctrl_ff;
				DMASC_ADDR_PERIPH: nxt_rdata = sel_full ? DMASC_READ_ZERO : periph_ff;
				DMASC_ADDR_MAR0: nxt_rdata = mar_ff[31:24];
				DMASC_ADDR_MAR1: nxt_rdata = mar_ff[23:16];
				DMASC_ADDR_MAR2: nxt_rdata = mar_ff[15:8];
				DMASC_ADDR_MAR3: nxt_rdata = mar_ff[7:0];
				DMASC_ADDR_IRQ_STAT: begin
					nxt_rdata = {6'h00, stat_ff};
					nxt_stat = 2'h0;
				end
				DMASC_ADDR_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
				default: nxt_rdata = DMASC_READ_ZERO;
			endcase
		end
		if (fire) begin
			if (ctrl_ff[DMASC_BIT_DIR]) begin
				nxt_mar = mar_ff - step;
			end else begin
				nxt_mar = mar_ff + step;
			end
			nxt_stat[DMASC_IRQ_BIT_XFER] = 1'b1;
		end
		if (end_evt) begin
			nxt_ctrl[DMASC_BIT_ENABLE] = 1'b0;
			if (ctrl_ff[DMASC_BIT_IRQEN]) begin
				nxt_stat[DMASC_IRQ_BIT_END] = 1'b1;
			end
		end
	end

	// Output stage next values, all registered.
	always_comb begin
		nxt_start = fire;
		nxt_full = sel_full;
		if (!nxt_ctrl[DMASC_BIT_REPEAT]) begin
			nxt_mode = DMASC_MODE_IO;
		end else if (!nxt_ctrl[DMASC_BIT_IRQEN]) begin
			nxt_mode = DMASC_MODE_REPEAT;
		end else begin
			nxt_mode = DMASC_MODE_IDLE;
		end
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	// State registers; all clear to zero at reset.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= DMASC_CTRL_RESET;
			periph_ff <= DMASC_PERIPH_RESET;
			mar_ff <= DMASC_MAR_RESET;
			stat_ff <= 2'h0;
			mask_ff <= 2'h0;
			rdata_ff <= DMASC_READ_ZERO;
			start_ff <= 1'b0;
			full_ff <= 1'b0;
			mode_ff <= DMASC_MODE_IO;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			periph_ff <= nxt_periph;
			mar_ff <= nxt_mar;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			start_ff <= nxt_start;
			full_ff <= nxt_full;
			mode_ff <= nxt_mode;
			irq_ff <= nxt_irq;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_xfer_start = start_ff;
	assign o_full_mode = full_ff;
	assign o_mode = mode_ff;
	assign o_mem_addr = mar_ff;
	assign o_periph_addr = periph_ff;
	assign o_irq = irq_ff;

	// Timer request of the selected channel starts a transfer one cycle later.
	timer_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[7] && !ctrl_ff[2] && i_timer_req[ctrl_ff[1:0]] && !i_count_done)
		|=> o_xfer_start)
		else $error("Timer request did not start a transfer.");

	// Serial transmit-empty request starts code 100 transfers.
	serial_txe_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[DMASC_BIT_ENABLE] && ctrl_ff[DMASC_SEL_HI:DMASC_SEL_LO] == DMASC_SEL_TXE)
		|=> (o_xfer_start == $past(i_txe_req)))
		else $error("Transmit-empty selection mismatch.");

	// Serial receive-full request starts code 101 transfers.
	serial_rxf_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[DMASC_BIT_ENABLE] && ctrl_ff[DMASC_SEL_HI:DMASC_SEL_LO] == DMASC_SEL_RXF)
		|=> (o_xfer_start == $past(i_rxf_req)))
		else $error("Receive-full selection mismatch.");

	// Codes 110 and 111 flag full address mode and never start short transfers.
	full_mode_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[2:1] == 2'h3) |=> (o_full_mode && !o_xfer_start))
		else $error("Full address mode not flagged.");

	// End of transfer flags status only with the interrupt enabled.
	end_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(end_evt && !ctrl_ff[3] && !stat_ff[0]) |=> !stat_ff[0])
		else $error("End interrupt raised while disabled.");

	// Peripheral byte ignores writes in full address mode.
	periph_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(i_wr && i_addr == DMASC_ADDR_PERIPH && sel_full) |=> $stable(periph_ff))
		else $error("Peripheral byte written in full address mode.");

	// Byte increment steps the memory address by exactly one.
	mar_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(fire && ctrl_ff[6:5] == 2'h0 && !i_wr) |=> (mar_ff == $past(mar_ff) + 32'h00000001))
		else $error("Memory address did not step by one.");

	// Mode output follows the repeat and irq-enable decode.
	mode_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[4:3] == 2'h2 && !i_wr && !end_evt) |=> (o_mode == 2'h1))
		else $error("Repeat mode decode wrong.");

	// Idle mode needs both the repeat bit and the irq-enable bit set.
	idle_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(ctrl_ff[DMASC_BIT_REPEAT] && ctrl_ff[DMASC_BIT_IRQEN] && !i_wr)
		|=> (o_mode == DMASC_MODE_IDLE))
		else $error("Idle mode decode wrong.");

	// A clear repeat bit always decodes as I/O mode, whatever the irq-enable bit says.
	io_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(!ctrl_ff[DMASC_BIT_REPEAT] && !i_wr) |=> (o_mode == DMASC_MODE_IO))
		else $error("I/O mode decode wrong.");

	// The peripheral byte reads as zero while full address mode hides it.
	periph_hidden_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(i_rd && i_addr == DMASC_ADDR_PERIPH && sel_full)
		|=> (o_rdata == DMASC_READ_ZERO))
		else $error("Peripheral byte visible in full address mode.");
endmodule : dmasc_chan

// *** tb/dmasc_src_model.sv ***
// Behavioural model of the timer and serial request sources.
`timescale 1ns/10ps
module dmasc_src_model(
	input wire logic [2:0] i_src,
	input wire logic i_fire,
	output logic [3:0] o_timer_req,
	output logic o_txe_req,
	output logic o_rxf_req
);
	// Only the named line rises; every other source stays quiet, as an idle peripheral would.
	assign o_timer_req = (i_fire && !i_src[2]) ? (4'h1 << i_src[1:0]) : 4'h0;
	assign o_txe_req = i_fire && (i_src == 3'h4);
	assign o_rxf_req = i_fire && (i_src == 3'h5);
endmodule : dmasc_src_model

// *** tb/dmasc_tb_top.sv ***
// Self-checking testbench for the short address channel control block.
`timescale 1ns/10ps
module dma_short_addr_channel_control_tb_top;
	import dmasc_pkg::*;
	logic i_core_clk, i_rstn, i_wr, i_rd, i_count_done, fire, i_txe_req, i_rxf_req;
	logic o_xfer_start, o_full_mode, o_irq;
	logic [7:0] i_addr, i_wdata, o_rdata, o_periph_addr;
	logic [2:0] src;
	logic [3:0] i_timer_req;
	logic [1:0] o_mode;
	logic [31:0] o_mem_addr, exp_mar;
	int errors, checks, cyc;
	dmasc_chan u_dut (.i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_timer_req,
		.i_txe_req, .i_rxf_req, .i_count_done, .o_rdata, .o_xfer_start, .o_full_mode,
		.o_mode, .o_mem_addr, .o_periph_addr, .o_irq);
	dmasc_src_model u_src (.i_src(src), .i_fire(fire), .o_timer_req(i_timer_req),
		.o_txe_req(i_txe_req), .o_rxf_req(i_rxf_req));
	// Compares one design value; case equality keeps an unknown from passing.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// One write cycle, then an idle edge so the strobe is never set twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		@(posedge i_core_clk);
	endtask : wr
	// Read data stands only in the cycle after the read edge, so it is sampled there.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp, "rdata");
		@(posedge i_core_clk);
	endtask : rd
	// Each short-mode code must ignore a foreign source and start on its own one.
	task automatic t_sources;
		for (int c = 0; c < 6; c++) begin
			wr(DMASC_ADDR_CTRL, 8'h80 | 8'(c));
			src <= 3'(c ^ 1);
			fire <= 1'b1;
			@(posedge i_core_clk);
			src <= 3'(c);
			#1 chk(o_xfer_start, 0, "foreign start");
			@(posedge i_core_clk);
			fire <= 1'b0;
			exp_mar = exp_mar + 1;
			#1 chk(o_xfer_start, 1, "start");
			chk(o_mem_addr, exp_mar, "mar step");
			@(posedge i_core_clk);
		end
		wr(DMASC_ADDR_CTRL, 8'h00);
		$display("sources test done");
	endtask : t_sources
	// Full address codes hide the peripheral byte; it must keep its short-mode value.
	task automatic t_full;
		wr(DMASC_ADDR_PERIPH, 8'h5A);
		rd(DMASC_ADDR_PERIPH, 8'h5A);
		for (int c = 6; c < 8; c++) begin
			wr(DMASC_ADDR_CTRL, 8'(c));
			#1 chk(o_full_mode, 1, "full mode");
			@(posedge i_core_clk);
			wr(DMASC_ADDR_PERIPH, 8'hA5);
			#1 chk(o_periph_addr, 8'h5A, "periph kept");
			@(posedge i_core_clk);
			rd(DMASC_ADDR_PERIPH, 8'h00);
		end
		wr(DMASC_ADDR_CTRL, 8'h00);
		#1 chk(o_full_mode, 0, "short mode");
		@(posedge i_core_clk);
		rd(DMASC_ADDR_PERIPH, 8'h5A);
		rd(8'h7F, 8'h00);
		$display("full mode test done");
	endtask : t_full
	// All four repeat and interrupt-enable pairs, with read-back of the register.
	task automatic t_modes;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			d = 8'(i) << 3;
			wr(DMASC_ADDR_CTRL, d);
			#1 chk(o_mode, {d[4] & d[3], d[4]}, "mode");
			@(posedge i_core_clk);
			rd(DMASC_ADDR_CTRL, d);
		end
		$display("modes test done");
	endtask : t_modes
	// The end event with interrupt enable set and then clear.
	task automatic t_irq;
		wr(DMASC_ADDR_IRQ_MASK, 8'h01);
		rd(DMASC_ADDR_IRQ_MASK, 8'h01);
		for (int e = 1; e >= 0; e--) begin
			rd(DMASC_ADDR_IRQ_STAT, e ? 8'h02 : 8'h00);
			wr(DMASC_ADDR_CTRL, 8'h80 | 8'(e << 3));
			i_count_done <= 1'b1;
			@(posedge i_core_clk);
			i_count_done <= 1'b0;
			repeat (2) @(posedge i_core_clk);
			#1 chk(o_irq, e, "irq");
			@(posedge i_core_clk);
			rd(DMASC_ADDR_CTRL, 8'(e << 3));
			rd(DMASC_ADDR_IRQ_STAT, 8'(e));
			@(posedge i_core_clk);
			#1 chk(o_irq, 0, "irq cleared");
			@(posedge i_core_clk);
		end
		$display("irq test done");
	endtask : t_irq
	// Byte lanes of the address register, then word steps up and down from the loaded value.
	task automatic t_mar;
		wr(DMASC_ADDR_MAR0, 8'h12);
		wr(DMASC_ADDR_MAR1, 8'h34);
		wr(DMASC_ADDR_MAR2, 8'h56);
		wr(DMASC_ADDR_MAR3, 8'h78);
		exp_mar = 32'h12345678;
		#1 chk(o_mem_addr, exp_mar, "mar load");
		@(posedge i_core_clk);
		rd(DMASC_ADDR_MAR0, 8'h12);
		rd(DMASC_ADDR_MAR3, 8'h78);
		wr(DMASC_ADDR_IRQ_MASK, 8'h02);
		// Enabled word transfers on code 100, first upwards, then with the direction bit set.
		for (int up = 1; up >= 0; up--) begin
			wr(DMASC_ADDR_CTRL, up ? 8'hC4 : 8'hE4);
			src <= DMASC_SEL_TXE;
			fire <= 1'b1;
			@(posedge i_core_clk);
			fire <= 1'b0;
			exp_mar = up ? exp_mar + DMASC_STEP_WORD : exp_mar - DMASC_STEP_WORD;
			#1 chk(o_xfer_start, 1, "word start");
			chk(o_mem_addr, exp_mar, "word step");
			@(posedge i_core_clk);
			#1 chk(o_irq, 1, "xfer irq");
			@(posedge i_core_clk);
			rd(DMASC_ADDR_IRQ_STAT, 8'h02);
		end
		wr(DMASC_ADDR_CTRL, 8'h00);
		wr(DMASC_ADDR_IRQ_MASK, 8'h00);
		$display("mar test done");
	endtask : t_mar
	// A reset in mid-run must clear the control, peripheral and address registers and the mode, full and irq outputs.
	task automatic t_reset;
		wr(DMASC_ADDR_PERIPH, 8'h3C);
		wr(DMASC_ADDR_CTRL, 8'h9F);
		#1 chk({o_full_mode, o_mode}, 3'h7, "before reset");
		@(posedge i_core_clk);
		i_rstn <= 1'b0;
		@(posedge i_core_clk);
		#1 chk({o_periph_addr, o_full_mode, o_mode, o_irq}, 12'h000, "outputs in reset");
		chk(o_mem_addr, DMASC_MAR_RESET, "mar in reset");
		@(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		rd(DMASC_ADDR_CTRL, DMASC_CTRL_RESET);
		rd(DMASC_ADDR_PERIPH, DMASC_PERIPH_RESET);
		$display("reset test done");
	endtask : t_reset
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	// A hang is cut short well beyond the fewer than two hundred cycles the tests need.
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		{i_rstn, i_wr, i_rd, i_count_done, fire, src, i_addr, i_wdata} = '0;
		exp_mar = DMASC_MAR_RESET;
		repeat (20) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		rd(DMASC_ADDR_CTRL, 8'h00);
		t_sources();
		t_full();
		t_modes();
		t_irq();
		t_mar();
		t_reset();
		wrap_up();
	end
endmodule : dma_short_addr_channel_control_tb_top
